//--- include/twb_pkg.sv
// Constants and types shared by the two-wire bus front end.
// Assumes a 125 MHz core clock; the divider table is the fixed one.
`default_nettype none

package twb_pkg;

  // ************************************************
  // Timing
  // ************************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int MAX_BIT_RATE_KBPS = 100;
  // Least bit period in core cycles, rounded up so the rate stays under
  localparam int MIN_BIT_CYC =
    (CLK_HZ + MAX_BIT_RATE_KBPS * 1000 - 1) / (MAX_BIT_RATE_KBPS * 1000);
  // Each bit is four quarter phases
  localparam int PHASES = 4;
  localparam int QTR_MIN = (MIN_BIT_CYC + PHASES - 1) / PHASES;
  localparam int QCNT_W = 11;
  localparam int DIV_W = 13;

  // ************************************************
  // Field widths and positions
  // ************************************************
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int FSEL_W = 5;
  localparam int RW_POS = 0;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  // ************************************************
  // Engine states
  // ************************************************
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_M_START = 3'b001,
    ST_M_HOLD  = 3'b010,
    ST_M_BIT   = 3'b011,
    ST_M_STOP  = 3'b100,
    ST_S_BIT   = 3'b101
  } state_t;

  // Serial clock divider, one of 32 settings, in core clock cycles
  function automatic logic [DIV_W-1:0] divider_of(
    input logic [FSEL_W-1:0] sel
  );
    logic [DIV_W-1:0] d;
    d = 13'h0016;
    case (sel)
      5'h00: d = 13'h0016;
      5'h01: d = 13'h0018;
      5'h02: d = 13'h001c;
      5'h03: d = 13'h0022;
      5'h04: d = 13'h002c;
      5'h05: d = 13'h0030;
      5'h06: d = 13'h0038;
      5'h07: d = 13'h0044;
      5'h08: d = 13'h0058;
      5'h09: d = 13'h0060;
      5'h0a: d = 13'h0070;
      5'h0b: d = 13'h0088;
      5'h0c: d = 13'h00b0;
      5'h0d: d = 13'h00c0;
      5'h0e: d = 13'h00e0;
      5'h0f: d = 13'h0110;
      5'h10: d = 13'h0160;
      5'h11: d = 13'h0180;
      5'h12: d = 13'h01c0;
      5'h13: d = 13'h0220;
      5'h14: d = 13'h02c0;
      5'h15: d = 13'h0300;
      5'h16: d = 13'h0380;
      5'h17: d = 13'h0440;
      5'h18: d = 13'h0580;
      5'h19: d = 13'h0600;
      5'h1a: d = 13'h0700;
      5'h1b: d = 13'h0880;
      5'h1c: d = 13'h0b00;
      5'h1d: d = 13'h0c00;
      5'h1e: d = 13'h0e00;
      default: d = 13'h1100;
    endcase
    return d;
  endfunction

endpackage

`default_nettype wire

//--- rtl/line_monitor.sv
// Link-side watcher of the two bus lines, on the link clock.
// Assumes srst_i comes from the core domain; it is resynchronised here.
`timescale 1ns/1ns
`default_nettype none

module line_monitor (
  input wire logic link_clk_i,
  input wire logic srst_i,
  input wire logic sda_i,
  input wire logic scl_i,
  output logic sda_lvl_o,
  output logic scl_lvl_o,
  output logic start_tgl_o,
  output logic stop_tgl_o
);

  logic rst_m_q, rst_q;
  logic sda_m_q, scl_m_q, sda_p_q, scl_p_q;

  // Reset and pins each pass two flops before use
  always_ff @(posedge link_clk_i) begin
    rst_m_q <= srst_i;
    rst_q <= rst_m_q;
    sda_m_q <= sda_i;
    scl_m_q <= scl_i;
    sda_lvl_o <= sda_m_q;
    scl_lvl_o <= scl_m_q;
    sda_p_q <= sda_lvl_o;
    scl_p_q <= scl_lvl_o;
  end

  // Start is SDA falling with SCL high, stop is SDA rising with SCL high;
  // events leave as toggles so the core can catch every one
  always_ff @(posedge link_clk_i) begin
    if (rst_q) begin
      start_tgl_o <= 1'b0;
      stop_tgl_o <= 1'b0;
    end else begin
      if (scl_lvl_o && scl_p_q && sda_p_q && !sda_lvl_o) begin // see RL1
        start_tgl_o <= !start_tgl_o; // see RL14
      end
      if (scl_lvl_o && scl_p_q && !sda_p_q && sda_lvl_o) begin // see RL17
        stop_tgl_o <= !stop_tgl_o; // see RL14
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/scl_divider.sv
// Quarter-bit tick generator for the master serial clock.
// Assumes the select is steady while a transfer runs.
`timescale 1ns/1ns
`default_nettype none

module scl_divider
  import twb_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic [FSEL_W-1:0] freq_sel_i,
  output logic tick_o
);

  logic [QCNT_W-1:0] cnt_q, reload;
  logic [DIV_W-1:0] div, bit_cyc, qtr;
  logic [QCNT_W-1:0] gap_q;

  // Table value clamped so no setting can beat the bus rate ceiling
  always_comb begin
    div = divider_of(freq_sel_i); // see RL9
    bit_cyc = (div < DIV_W'(MIN_BIT_CYC)) ? DIV_W'(MIN_BIT_CYC) : div; // see RL7
    qtr = (bit_cyc + DIV_W'(PHASES - 1)) >> 2;
    reload = QCNT_W'(qtr - 13'h0001);
  end

  // Restarts whenever the engine leaves a timed state, so phases align
  always_ff @(posedge clock_i) begin
    if (srst_i || !run_i) begin
      cnt_q <= reload;
      tick_o <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q <= reload;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 11'h001;
      tick_o <= 1'b0;
    end
  end

  // Helper for the spacing check only
  always_ff @(posedge clock_i) begin
    if (srst_i || !run_i || tick_o) begin
      gap_q <= '0;
    end else if (gap_q != '1) begin
      gap_q <= gap_q + 11'h001;
    end
  end

  localparam int GAP_MIN = QTR_MIN - 1;

  a_tick_spacing: assert property (@(posedge clock_i) disable iff (srst_i) // see RL7
    (tick_o && $past(run_i) && $past(tick_o, 2) == 1'b0 && gap_q != '0)
      |-> gap_q >= GAP_MIN)
    else $error("serial clock quarter shorter than rate floor");

endmodule

`default_nettype wire

//--- rtl/two_wire_bus_start_address.sv
// Protocol engine for a multimaster two-wire serial bus: start, address,
// acknowledge, byte transfer, stop and arbitration, as master or slave.
// Assumes open-drain pads outside and user controls on clock_i.
//
// Overview of operation
// RL1 - Start is SDA falling while SCL is high; all parties see it.
// RL2 - A master starts only when the bus is free, both lines high.
// RL3 - After start, first byte is seven address bits then direction bit.
// RL4 - Slave uses the direction bit to pick receive or transmit.
// RL5 - Only the matching slave pulls SDA low on the ninth clock.
// RL6 - Both lines are only ever pulled low or released.
// RL7 - Generated serial clock never exceeds 100 kilobits per second.
// RL8 - Several masters coexist; collisions are detected and arbitrated.
// RL9 - Master clock frequency is one of 32 selectable settings.
// RL10 - Losing arbitration drops to slave mode and reports the loss.
// RL11 - Being addressed as slave is reported.
// RL12 - Data moves a byte at a time with a report per byte.
// RL13 - Acknowledge sent is selectable; the far acknowledge is captured.
// RL14 - Start and stop are both generated and detected.
// RL15 - Master can issue a repeated start without a stop.
// RL16 - Transfer order: start, address, data bytes, stop.
// RL17 - Stop is SDA rising while SCL is high; it frees the bus.
// RL18 - Bytes are eight bits, MSB first, each followed by acknowledge.
// RL19 - Master sending one while bus shows zero releases both lines.
// RL20 - Busy runs from a detected start to a detected stop.
// RL21 - Lines are synchronised to the local clock before edge detection.
`timescale 1ns/1ns
`default_nettype none

module two_wire_bus_start_address
  import twb_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic link_clk_i,
  input wire logic sda_i,
  input wire logic scl_i,
  input wire logic enable_i,
  input wire logic master_i,
  input wire logic rstart_i,
  input wire logic go_i,
  input wire logic tx_mode_i,
  input wire logic ack_off_i,
  input wire logic [ADDR_W-1:0] own_addr_i,
  input wire logic [FSEL_W-1:0] freq_sel_i,
  input wire logic [BYTE_W-1:0] tx_data_i,
  output logic sda_o,
  output logic sda_drive_n_o,
  output logic scl_o,
  output logic scl_drive_n_o,
  output logic busy_o,
  output logic master_o,
  output logic slave_tx_o,
  output logic [BYTE_W-1:0] rx_data_o,
  output logic ack_rcvd_o,
  output logic byte_done_o,
  output logic arb_lost_o,
  output logic addressed_o
);

  // ************************************************
  // Line sampling and crossing
  // ************************************************
  logic sda_lk, scl_lk, start_tgl, stop_tgl;
  logic sda_m_q, scl_m_q, sda_q, scl_q, scl_p_q;
  logic st_m_q, sp_m_q, st_s_q, sp_s_q, st_p_q, sp_p_q;
  logic start_ev, stop_ev, scl_rise, scl_fall;

  line_monitor u_mon (
    .link_clk_i(link_clk_i),
    .srst_i(srst_i),
    .sda_i(sda_i),
    .scl_i(scl_i),
    .sda_lvl_o(sda_lk),
    .scl_lvl_o(scl_lk),
    .start_tgl_o(start_tgl),
    .stop_tgl_o(stop_tgl)
  );

  // Levels and toggles re-enter the core domain through two flops each
  always_ff @(posedge clock_i) begin
    sda_m_q <= sda_lk; // see RL21
    scl_m_q <= scl_lk;
    sda_q <= sda_m_q;
    scl_q <= scl_m_q;
    scl_p_q <= scl_q;
    st_m_q <= start_tgl;
    sp_m_q <= stop_tgl;
    st_s_q <= st_m_q;
    sp_s_q <= sp_m_q;
    st_p_q <= st_s_q;
    sp_p_q <= sp_s_q;
  end

  assign start_ev = st_s_q ^ st_p_q;
  assign stop_ev = sp_s_q ^ sp_p_q;
  assign scl_rise = scl_q && !scl_p_q;
  assign scl_fall = !scl_q && scl_p_q;

  // ************************************************
  // Bus busy tracking
  // ************************************************
  // Stop wins if both arrive together, since a stop leaves the bus free
  always_ff @(posedge clock_i) begin
    if (srst_i || !enable_i) begin
      busy_o <= 1'b0;
    end else if (stop_ev) begin
      busy_o <= 1'b0; // see RL17
    end else if (start_ev) begin
      busy_o <= 1'b1; // see RL20
    end
  end

  // ************************************************
  // Master quarter-phase timing
  // ************************************************
  state_t st_q;
  logic tick, run, mreq_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [BYTE_W-1:0] shreg_q, txsh_q;
  logic addr_ph_q;
  logic free;
  // A slave count starts one below bit zero: the SCL fall that ends a
  // start carries no data, and wrapping on it lands the count on bit zero
  localparam logic [3:0] BIT_PRE = 4'hf;

  assign run = (st_q == ST_M_START) || (st_q == ST_M_BIT)
            || (st_q == ST_M_STOP);
  // Free needs both lines high as well as no start pending
  assign free = !busy_o && sda_q && scl_q; // see RL2

  scl_divider u_div (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .run_i(run),
    .freq_sel_i(freq_sel_i),
    .tick_o(tick)
  );

  always_ff @(posedge clock_i) begin
    mreq_q <= srst_i ? 1'b0 : master_i;
  end

  // Pads only ever pull low; the enables decide the wire
  always_ff @(posedge clock_i) begin
    sda_o <= 1'b0; // see RL6
    scl_o <= 1'b0; // see RL6
  end

  // ************************************************
  // Protocol engine
  // ************************************************
  always_ff @(posedge clock_i) begin
    byte_done_o <= 1'b0;
    arb_lost_o <= 1'b0;
    addressed_o <= 1'b0;
    if (srst_i || !enable_i) begin
      st_q <= ST_IDLE;
      ph_q <= PH_SET;
      bit_q <= 4'h0;
      shreg_q <= '0;
      txsh_q <= '0;
      addr_ph_q <= 1'b0;
      sda_drive_n_o <= 1'b1;
      scl_drive_n_o <= 1'b1;
      master_o <= 1'b0;
      slave_tx_o <= 1'b0;
      rx_data_o <= '0;
      ack_rcvd_o <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          sda_drive_n_o <= 1'b1;
          scl_drive_n_o <= 1'b1;
          if (master_i && !mreq_q && free) begin // see RL2
            st_q <= ST_M_START;
            ph_q <= PH_SET;
            master_o <= 1'b1;
          end else if (start_ev) begin // see RL1
            st_q <= ST_S_BIT;
            bit_q <= BIT_PRE;
            addr_ph_q <= 1'b1;
            slave_tx_o <= 1'b0;
          end
        end
        // Also serves repeated start: release both, then SDA low, SCL low
        ST_M_START: begin
          if (tick) begin
            unique case (ph_q)
              PH_SET: begin
                sda_drive_n_o <= 1'b1;
                scl_drive_n_o <= 1'b1;
                ph_q <= PH_RISE;
              end
              PH_RISE: begin
                if (scl_q && sda_q) begin
                  sda_drive_n_o <= 1'b0; // see RL1
                  ph_q <= PH_HIGH;
                end
              end
              default: begin
                scl_drive_n_o <= 1'b0;
                addr_ph_q <= 1'b1; // see RL3
                bit_q <= 4'h0;
                st_q <= ST_M_HOLD;
              end
            endcase
          end
        end
        // SCL held low while software decides the next step
        ST_M_HOLD: begin
          if (!master_i) begin
            st_q <= ST_M_STOP; // see RL16
            ph_q <= PH_SET;
          end else if (rstart_i) begin
            st_q <= ST_M_START; // see RL15
            ph_q <= PH_SET;
          end else if (go_i) begin
            st_q <= ST_M_BIT;
            ph_q <= PH_SET;
            bit_q <= 4'h0;
            txsh_q <= tx_data_i;
          end
        end
        ST_M_BIT: begin
          if (tick) begin
            unique case (ph_q)
              PH_SET: begin
                if (bit_q <= LAST_DATA_BIT) begin
                  // MSB first while sending; released while receiving
                  sda_drive_n_o <= tx_mode_i ? txsh_q[BYTE_W-1] : 1'b1;
                  txsh_q <= {txsh_q[BYTE_W-2:0], 1'b0}; // see RL18
                end else begin
                  sda_drive_n_o <= tx_mode_i || ack_off_i; // see RL13
                end
                ph_q <= PH_RISE;
              end
              PH_RISE: begin
                scl_drive_n_o <= 1'b1;
                // A slower party may hold SCL low; wait it out
                if (scl_q) begin
                  ph_q <= PH_HIGH;
                end
              end
              PH_HIGH: begin
                if (bit_q <= LAST_DATA_BIT) begin
                  shreg_q <= {shreg_q[BYTE_W-2:0], sda_q};
                end else if (tx_mode_i) begin
                  ack_rcvd_o <= !sda_q; // see RL13
                end
                if (tx_mode_i && bit_q <= LAST_DATA_BIT
                    && sda_drive_n_o && !sda_q) begin
                  // Lost: let go of both lines at once, carry on as slave
                  sda_drive_n_o <= 1'b1; // see RL19
                  scl_drive_n_o <= 1'b1; // see RL19
                  master_o <= 1'b0; // see RL10
                  arb_lost_o <= 1'b1; // see RL8
                  slave_tx_o <= 1'b0;
                  st_q <= ST_S_BIT;
                end else begin
                  ph_q <= PH_FALL;
                end
              end
              default: begin
                scl_drive_n_o <= 1'b0;
                ph_q <= PH_SET;
                if (bit_q == ACK_BIT) begin
                  sda_drive_n_o <= 1'b1;
                  rx_data_o <= shreg_q;
                  byte_done_o <= 1'b1; // see RL12
                  addr_ph_q <= 1'b0;
                  st_q <= ST_M_HOLD;
                end else begin
                  bit_q <= bit_q + 4'h1;
                end
              end
            endcase
          end
        end
        // SDA low under low SCL, release SCL, then release SDA
        ST_M_STOP: begin
          if (tick) begin
            unique case (ph_q)
              PH_SET: begin
                sda_drive_n_o <= 1'b0;
                ph_q <= PH_RISE;
              end
              PH_RISE: begin
                scl_drive_n_o <= 1'b1;
                if (scl_q) begin
                  ph_q <= PH_HIGH;
                end
              end
              default: begin
                sda_drive_n_o <= 1'b1; // see RL17
                master_o <= 1'b0;
                st_q <= ST_IDLE;
              end
            endcase
          end
        end
        // Slave: sample on SCL rise, change SDA on SCL fall
        ST_S_BIT: begin
          if (stop_ev) begin
            sda_drive_n_o <= 1'b1;
            slave_tx_o <= 1'b0;
            st_q <= ST_IDLE;
          end else if (start_ev) begin
            sda_drive_n_o <= 1'b1;
            bit_q <= BIT_PRE;
            addr_ph_q <= 1'b1;
            slave_tx_o <= 1'b0;
          end else if (scl_rise) begin
            if (bit_q <= LAST_DATA_BIT) begin
              shreg_q <= {shreg_q[BYTE_W-2:0], sda_q}; // see RL18
            end else if (slave_tx_o) begin
              ack_rcvd_o <= !sda_q; // see RL13
            end
          end else if (scl_fall) begin
            if (bit_q == LAST_DATA_BIT) begin
              bit_q <= ACK_BIT;
              if (addr_ph_q) begin
                if (shreg_q[BYTE_W-1:1] == own_addr_i) begin
                  sda_drive_n_o <= 1'b0; // see RL5
                  addressed_o <= 1'b1; // see RL11
                  slave_tx_o <= shreg_q[RW_POS]; // see RL4
                end else begin
                  st_q <= ST_IDLE; // see RL5
                end
              end else begin
                sda_drive_n_o <= slave_tx_o || ack_off_i; // see RL13
              end
            end else if (bit_q == ACK_BIT) begin
              bit_q <= 4'h0;
              addr_ph_q <= 1'b0;
              rx_data_o <= shreg_q;
              byte_done_o <= 1'b1; // see RL12
              if (slave_tx_o && !addr_ph_q && !ack_rcvd_o) begin
                // Master ended the read; leave SDA for its stop
                sda_drive_n_o <= 1'b1;
                slave_tx_o <= 1'b0;
                st_q <= ST_IDLE;
              end else if (slave_tx_o) begin
                sda_drive_n_o <= tx_data_i[BYTE_W-1]; // see RL18
                txsh_q <= {tx_data_i[BYTE_W-2:0], 1'b0};
              end else begin
                sda_drive_n_o <= 1'b1;
              end
            end else begin
              bit_q <= bit_q + 4'h1;
              if (slave_tx_o) begin
                sda_drive_n_o <= txsh_q[BYTE_W-1];
                txsh_q <= {txsh_q[BYTE_W-2:0], 1'b0};
              end
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  a_start_when_free: assert property ( // see RL2
    $rose(master_o) |-> $past(free, 1) && $past(st_q == ST_IDLE, 1))
    else $error("master started on a busy bus");

  a_start_shape: assert property ( // see RL1
    (st_q == ST_M_START && ph_q == PH_RISE && tick && scl_q && sda_q)
      |=> !sda_drive_n_o && scl_drive_n_o)
    else $error("start not SDA low under high SCL");

  a_stop_shape: assert property ( // see RL17
    (st_q == ST_M_STOP && ph_q == PH_HIGH && tick)
      |=> sda_drive_n_o && scl_drive_n_o && st_q == ST_IDLE)
    else $error("stop did not release SDA after SCL");

  a_pads_low_only: assert property ( // see RL6
    !sda_o && !scl_o)
    else $error("pad output driven high");

  a_arb_release: assert property ( // see RL19
    arb_lost_o |-> sda_drive_n_o && scl_drive_n_o && !master_o
      && st_q == ST_S_BIT)
    else $error("lines held after arbitration loss");

  a_addr_match_ack: assert property ( // see RL5
    addressed_o |-> !sda_drive_n_o
      && $past(shreg_q[BYTE_W-1:1], 1) == own_addr_i)
    else $error("acknowledge without address match");

  a_direction_bit: assert property ( // see RL4
    addressed_o |-> slave_tx_o == $past(shreg_q[RW_POS], 1))
    else $error("slave direction not taken from address byte");

  a_busy_track: assert property ( // see RL20
    (start_ev && !stop_ev && enable_i) |=> busy_o)
    else $error("busy not raised on start");

  a_busy_clear: assert property ( // see RL17
    stop_ev |=> !busy_o)
    else $error("busy not cleared on stop");

  a_byte_report: assert property ( // see RL12
    (st_q == ST_M_BIT && ph_q == PH_FALL && tick && bit_q == ACK_BIT)
      |=> byte_done_o && st_q == ST_M_HOLD && rx_data_o == $past(shreg_q))
    else $error("master byte end not reported");

  c_addressed: cover property (addressed_o);
  c_arb_lost: cover property (arb_lost_o);
  c_master_byte: cover property (byte_done_o && master_o);
  c_rstart: cover property (st_q == ST_M_HOLD && rstart_i && master_i);

endmodule

`default_nettype wire

//--- verif/bus_partner.sv
// Far-side model: a slave acking one address, and a master task.
// Assumes the bench resolves both wires with pull-ups.
`timescale 1ns/1ns
`default_nettype none

module bus_partner #(
  parameter logic [6:0] ADDR = 7'h2c,
  parameter int Q = 500
) (
  input wire logic sda_i,
  input wire logic scl_i,
  output logic sda_pull_o,
  output logic scl_pull_o
);
  // ****************
  // Slave side
  // ****************
  logic [7:0] got[$];
  logic [7:0] sh;
  int nb;
  logic on = 0, first = 0, hit = 0, arb = 0, mst = 0;
  logic s_pull = 0, m_sda = 0, m_scl = 0;
  // Pulled low or let go, never driven high
  assign sda_pull_o = s_pull | m_sda;
  assign scl_pull_o = m_scl;
  // Start and stop are SDA edges while SCL is high
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      on = 1;
      nb = 0;
      first = 1;
    end
  end
  always @(posedge sda_i) if (scl_i === 1'b1) on = 0;
  // Bits shift in MSB first on the first eight SCL rises of each byte
  always @(posedge scl_i) begin
    if (on && !mst) begin
      if (nb < 8) sh = {sh[6:0], sda_i};
      nb++;
    end
  end
  // Acks only a matching call; arb mode then acts as a rival sending 0
  always @(negedge scl_i) begin
    if (on && !mst && nb == 8) begin
      got.push_back(sh);
      if (first) hit = sh[7:1] == ADDR;
      first = 0;
      s_pull = hit;
    end else if (on && !mst && nb == 9) begin
      s_pull = arb && hit;
      nb = 0;
    end
  end
  // Master: start, call MSB first, ack clock, stop; caller waits for free
  task automatic wr(input logic [7:0] b, output logic ack);
    mst = 1;
    m_sda = 1;
    #Q m_scl = 1;
    for (int i = 7; i >= 0; i--) begin
      m_sda = !b[i];
      #Q m_scl = 0;
      #Q m_scl = 1;
    end
    m_sda = 0;
    #Q m_scl = 0;
    #Q ack = !sda_i;
    m_scl = 1;
    #Q m_sda = 1;
    #Q m_scl = 0;
    #Q m_sda = 0;
    #Q mst = 0;
  endtask
endmodule

`default_nettype wire

//--- verif/two_wire_bus_start_address_tb_top.sv
// Bench for the two-wire front end against the far-side model.
// Assumes open-drain wires resolved here with pull-ups.
`timescale 1ns/1ns
`default_nettype none

module two_wire_bus_start_address_tb_top;
  import twb_pkg::*;
  // ****************
  // Wires and clocks
  // ****************
  localparam logic [6:0] P_ADDR = 7'h2c;
  logic clk = 0, lclk = 0, srst = 1, master = 0, go = 0, rstart = 0, ack;
  logic sda, scl, p_sda, p_scl, sda_dn, scl_dn, busy, mst_o, stx;
  logic ack_r, bdone, arb_l, adr;
  logic [6:0] own = 7'h40;
  logic [4:0] fsel = 5'h00;
  logic [7:0] txd = 8'h00, seed = 8'h56, rxd;
  int n_errors = 0, checked = 0, cyc = 0, n_adr = 0;
  time t_scl = 0;
  // Wired-AND: any pull wins
  assign sda = !(!sda_dn || p_sda);
  assign scl = !(!scl_dn || p_scl);
  always #4 clk = ~clk;
  // Link clock of 15 ns, phase unrelated to the core clock
  initial begin
    #3;
    forever begin
      #7 lclk = 1;
      #8 lclk = 0;
    end
  end
  two_wire_bus_start_address u_two_wire_bus_start_address (
    .clock_i(clk), .srst_i(srst), .link_clk_i(lclk), .sda_i(sda),
    .scl_i(scl), .enable_i(1'b1), .master_i(master), .rstart_i(rstart),
    .go_i(go), .tx_mode_i(1'b1), .ack_off_i(1'b0), .own_addr_i(own),
    .freq_sel_i(fsel), .tx_data_i(txd), .sda_o(), .sda_drive_n_o(sda_dn),
    .scl_o(), .scl_drive_n_o(scl_dn), .busy_o(busy), .master_o(mst_o),
    .slave_tx_o(stx), .rx_data_o(rxd), .ack_rcvd_o(ack_r),
    .byte_done_o(bdone), .arb_lost_o(arb_l), .addressed_o(adr)
  );
  bus_partner #(.ADDR(P_ADDR)) u_bus_partner (
    .sda_i(sda), .scl_i(scl), .sda_pull_o(p_sda), .scl_pull_o(p_scl)
  );
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Write call: address above a zero direction bit
  function automatic logic [7:0] call(input logic [6:0] a);
    return {a, 1'b0};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Request the bus and wait for the hold with SCL low
  task automatic mstart;
    @(negedge clk) master = 1;
    wait (scl_dn === 1'b0);
    @(negedge clk) check(busy, 1);
    check(mst_o, 1);
  endtask
  // Gap first, so go never lands in the cycle after a byte ends
  task automatic launch(input logic [7:0] b);
    repeat (4) @(negedge clk);
    txd = b;
    go = 1;
    @(negedge clk) go = 0;
  endtask
  task automatic mbyte(input logic [7:0] b);
    launch(b);
    @(posedge clk iff bdone === 1'b1);
    @(negedge clk) check(ack_r, 1);
  endtask
  // Hang guard: the run needs about 65k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      finish_test;
    end
  end
  always @(posedge clk) if (adr === 1'b1) n_adr++;
  // As master, SCL rises stay at least 10 us apart
  always @(posedge scl) begin
    if (mst_o === 1'b1 && t_scl != 0)
      check(8'($time - t_scl >= 10000), 1);
    t_scl = (mst_o === 1'b1) ? $time : 0;
  end
  initial begin
    repeat (3) @(negedge clk);
    srst = 0;
    seed = lfsr(seed);
    own = {1'b1, seed[5:0]};
    fsel = {1'b0, seed[3:0]};
    repeat (6) @(negedge clk);
    // Master write: start and call, left in hold; the random byte and stop follow the repeated start
    seed = lfsr(seed);
    mstart;
    mbyte(call(P_ADDR));
    // Repeated start from hold, then the same call again
    @(negedge clk) rstart = 1;
    @(negedge clk) rstart = 0;
    wait (scl_dn === 1'b1);
    wait (scl_dn === 1'b0);
    mbyte(call(P_ADDR));
    mbyte(seed);
    @(negedge clk) master = 0;
    wait (busy === 1'b0);
    @(negedge clk) check(mst_o, 0);
    check(u_bus_partner.got[0], call(P_ADDR));
    check(u_bus_partner.got[1], call(P_ADDR));
    check(u_bus_partner.got[2], seed);
    // Far master calls us while we try to start
    fork
      u_bus_partner.wr(call(own), ack);
      begin
        wait (busy === 1'b1);
        @(negedge clk) master = 1;
        repeat (300) @(negedge clk);
        check(mst_o, 0);
        master = 0;
      end
    join
    @(negedge clk) check(ack, 1);
    check(8'(n_adr), 1);
    check(rxd, call(own));
    check(stx, 0);
    check(busy, 0);
    // Call to another address: no ack, no event
    u_bus_partner.wr(call(~own), ack);
    @(negedge clk) check(ack, 0);
    check(8'(n_adr), 1);
    // Rival pulls SDA low while we send a 1
    u_bus_partner.arb = 1;
    mstart;
    mbyte(call(P_ADDR));
    launch(8'hff);
    @(posedge clk iff arb_l === 1'b1);
    @(negedge clk) check(mst_o, 0);
    check({6'h00, sda_dn, scl_dn}, 8'h03);
    finish_test;
  end
endmodule

`default_nettype wire
